// ### timer4_compare_unit.sv
`timescale 1ns/1ns
module timer4_compare_unit
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [3:0] reg_index,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Timer control from the rest of the timer
   input wire logic timer_tick,
   input wire logic pwm_enable,
   input wire logic [1:0] wave_mode,
   input wire logic match_a_event,
   // Interrupt controller
   input wire logic global_irq_enable,
   input wire logic vector_ack_d,
   input wire logic vector_ack_a,
   input wire logic vector_ack_b,
   input wire logic vector_ack_overflow,
   output logic irq_match_d,
   output logic irq_match_a,
   output logic irq_match_b,
   output logic irq_overflow,
   // Counter state and compare outputs
   output logic [9:0] counter_value,
   output logic match_b_pulse,
   output logic match_d_pulse,
   output logic top_match_pulse,
   output logic [3:0] compare_output_pin
);

   logic [1:0] shared_high_bits;
   logic [9:0] buffered_value [3];
   logic [9:0] active_value [3];
   logic [7:0] timer_irq_mask;
   logic [7:0] timer_irq_flags;
   logic [7:0] deadtime_value;
   timer4_pkg::count_dir_type count_dir;
   timer4_pkg::count_dir_type next_dir;
   logic [9:0] next_count;
   logic wrap_event;
   logic bottom_event;
   logic dual_slope;
   logic overflow_event;
   logic update_event;
   logic [9:0] wide_wdata;
   logic [9:0] period_wdata;
   logic match_b_sync;
   logic match_d_sync;
   logic match_a_sync;
   logic [3:0] flag_set;
   logic [3:0] flag_ack;
   logic [3:0] clear_pending;
   logic [3:0] flag_bit;
   logic [3:0] mask_bit;
   logic [7:0] read_value;
   logic wave_b;
   logic wave_d;

   // True for the registers that take part in the shared high-bits sequence
   function automatic logic is_wide_reg(input logic [3:0] idx);
      is_wide_reg = (idx == timer4_pkg::IDX_COUNTER) || (idx == timer4_pkg::IDX_COMPARE_B)
         || (idx == timer4_pkg::IDX_PERIOD_TOP) || (idx == timer4_pkg::IDX_COMPARE_D);
   endfunction

   function automatic logic write_to(input logic [3:0] idx);
      write_to = reg_write && (reg_index == idx);
   endfunction

   assign dual_slope = pwm_enable && wave_mode[0];
   assign wide_wdata = {shared_high_bits, reg_wdata};
   assign period_wdata = (wide_wdata < timer4_pkg::MIN_PERIOD_TOP)
      ? timer4_pkg::MIN_PERIOD_TOP : wide_wdata;

   // Next counter value, direction and boundary events
   always_comb
   begin
      next_count = counter_value;
      next_dir = count_dir;
      wrap_event = 1'b0;
      bottom_event = 1'b0;
      top_match_pulse = 1'b0;
      if (timer_tick)
      begin
         if (dual_slope)
         begin
            if (count_dir == timer4_pkg::COUNT_UP)
            begin
               if (counter_value >= active_value[timer4_pkg::CH_C])
               begin
                  top_match_pulse = 1'b1;
                  next_dir = timer4_pkg::COUNT_DOWN;
                  next_count = counter_value - 10'h001;
               end
               else
               begin
                  next_count = counter_value + 10'h001;
               end
            end
            else if (counter_value == 10'h000)
            begin
               next_dir = timer4_pkg::COUNT_UP;
               next_count = 10'h001;
            end
            else
            begin
               next_count = counter_value - 10'h001;
               if (counter_value == 10'h001)
               begin
                  bottom_event = 1'b1;
                  next_dir = timer4_pkg::COUNT_UP;
               end
            end
         end
         else if (counter_value >= active_value[timer4_pkg::CH_C])
         begin
            top_match_pulse = 1'b1;
            wrap_event = 1'b1;
            next_count = 10'h000;
         end
         else
         begin
            next_count = counter_value + 10'h001;
         end
      end
   end

   assign overflow_event = dual_slope ? bottom_event : wrap_event;
   assign update_event = dual_slope ? bottom_event : wrap_event;

   // Only a counting step can land on the value, never a register write
   // A counter load wins over the step, so the stepped value never lands
   assign match_b_pulse = timer_tick && (next_count != counter_value)
      && !(reg_write && (reg_index == timer4_pkg::IDX_COUNTER))
      && (next_count == active_value[timer4_pkg::CH_B]);
   assign match_d_pulse = timer_tick && (next_count != counter_value)
      && !(reg_write && (reg_index == timer4_pkg::IDX_COUNTER))
      && (next_count == active_value[timer4_pkg::CH_D]);

   // Counter; a software load restarts counting upward
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         counter_value <= timer4_pkg::RESET_COUNTER;
         count_dir <= timer4_pkg::COUNT_UP;
      end
      else if (write_to(timer4_pkg::IDX_COUNTER))
      begin
         counter_value <= wide_wdata;
         count_dir <= timer4_pkg::COUNT_UP;
      end
      else
      begin
         counter_value <= next_count;
         count_dir <= next_dir;
      end
   end

   // Compare values: buffered copy for reads, active copy for matching
   generate
      for (genvar ch = 0; ch < 3; ch++)
      begin : g_compare
         localparam logic [3:0] CH_IDX = (ch == timer4_pkg::CH_B) ? timer4_pkg::IDX_COMPARE_B
            : (ch == timer4_pkg::CH_C) ? timer4_pkg::IDX_PERIOD_TOP
            : timer4_pkg::IDX_COMPARE_D;
         localparam logic [9:0] CH_RESET = (ch == timer4_pkg::CH_C)
            ? timer4_pkg::RESET_PERIOD_TOP : timer4_pkg::RESET_COMPARE;
         logic [9:0] ch_wdata;
         assign ch_wdata = (ch == timer4_pkg::CH_C) ? period_wdata : wide_wdata;

         always_ff @(posedge ref_clk)
         begin
            if (!rst_n)
            begin
               buffered_value[ch] <= CH_RESET;
               active_value[ch] <= CH_RESET;
            end
            else if (write_to(CH_IDX))
            begin
               buffered_value[ch] <= ch_wdata;
               if (!pwm_enable)
               begin
                  active_value[ch] <= ch_wdata;
               end
            end
            else if (update_event)
            begin
               active_value[ch] <= buffered_value[ch];
            end
         end
      end
   endgenerate

   // Shared high bits: written directly, loaded by every wide low-byte read
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         shared_high_bits <= timer4_pkg::RESET_SHARED_HIGH;
      end
      else if (write_to(timer4_pkg::IDX_SHARED_HIGH))
      begin
         shared_high_bits <= reg_wdata[1:0];
      end
      else if (reg_read && is_wide_reg(reg_index))
      begin
         case (reg_index)
            timer4_pkg::IDX_COUNTER: shared_high_bits <= counter_value[9:8];
            timer4_pkg::IDX_COMPARE_B: shared_high_bits <= buffered_value[0][9:8];
            timer4_pkg::IDX_PERIOD_TOP: shared_high_bits <= buffered_value[1][9:8];
            timer4_pkg::IDX_COMPARE_D: shared_high_bits <= buffered_value[2][9:8];
            default: shared_high_bits <= shared_high_bits;
         endcase
      end
   end

   // Mask and dead-time registers
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         timer_irq_mask <= timer4_pkg::RESET_IRQ_MASK;
      end
      else if (write_to(timer4_pkg::IDX_IRQ_MASK))
      begin
         timer_irq_mask <= reg_wdata & timer4_pkg::IRQ_BITS_USED;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         deadtime_value <= timer4_pkg::RESET_DEADTIME;
      end
      else if (write_to(timer4_pkg::IDX_DEADTIME))
      begin
         deadtime_value <= reg_wdata;
      end
   end

   // Synchronising stage between a match and its flag
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         match_b_sync <= 1'b0;
         match_d_sync <= 1'b0;
         match_a_sync <= 1'b0;
      end
      else
      begin
         match_b_sync <= match_b_pulse;
         match_d_sync <= match_d_pulse;
         match_a_sync <= match_a_event;
      end
   end

   // Slot order: 3 = D, 2 = A, 1 = B, 0 = overflow
   assign flag_set = {match_d_sync, match_a_sync, match_b_sync, overflow_event};
   assign flag_ack = {vector_ack_d, vector_ack_a, vector_ack_b, vector_ack_overflow};
   assign mask_bit = {timer_irq_mask[timer4_pkg::POS_MATCH_D],
      timer_irq_mask[timer4_pkg::POS_MATCH_A],
      timer_irq_mask[timer4_pkg::POS_MATCH_B],
      timer_irq_mask[timer4_pkg::POS_OVERFLOW]};

   generate
      for (genvar f = 0; f < 4; f++)
      begin : g_flag
         localparam int POS = (f == 3) ? timer4_pkg::POS_MATCH_D
            : (f == 2) ? timer4_pkg::POS_MATCH_A
            : (f == 1) ? timer4_pkg::POS_MATCH_B : timer4_pkg::POS_OVERFLOW;

         // Write-one clear lands one cycle late; a new set always wins
         always_ff @(posedge ref_clk)
         begin
            if (!rst_n)
            begin
               clear_pending[f] <= 1'b0;
               flag_bit[f] <= 1'b0;
            end
            else
            begin
               clear_pending[f] <= write_to(timer4_pkg::IDX_IRQ_FLAGS)
                  && reg_wdata[POS];
               flag_bit[f] <= flag_set[f]
                  || (flag_bit[f] && !clear_pending[f] && !flag_ack[f]);
            end
         end
      end
   endgenerate

   always_comb
   begin
      timer_irq_flags = 8'h00;
      timer_irq_flags[timer4_pkg::POS_MATCH_D] = flag_bit[3];
      timer_irq_flags[timer4_pkg::POS_MATCH_A] = flag_bit[2];
      timer_irq_flags[timer4_pkg::POS_MATCH_B] = flag_bit[1];
      timer_irq_flags[timer4_pkg::POS_OVERFLOW] = flag_bit[0];
   end

   // Requests follow global enable, mask and flag together
   assign irq_match_d = global_irq_enable && mask_bit[3] && flag_bit[3];
   assign irq_match_a = global_irq_enable && mask_bit[2] && flag_bit[2];
   assign irq_match_b = global_irq_enable && mask_bit[1] && flag_bit[1];
   assign irq_overflow = global_irq_enable && mask_bit[0] && flag_bit[0];

   // Read data
   always_comb
   begin
      case (reg_index)
         timer4_pkg::IDX_COUNTER: read_value = counter_value[7:0];
         timer4_pkg::IDX_SHARED_HIGH: read_value = {6'h00, shared_high_bits};
         timer4_pkg::IDX_COMPARE_B: read_value = buffered_value[0][7:0];
         timer4_pkg::IDX_PERIOD_TOP: read_value = buffered_value[1][7:0];
         timer4_pkg::IDX_COMPARE_D: read_value = buffered_value[2][7:0];
         timer4_pkg::IDX_IRQ_MASK: read_value = timer_irq_mask;
         timer4_pkg::IDX_IRQ_FLAGS: read_value = timer_irq_flags;
         timer4_pkg::IDX_DEADTIME: read_value = deadtime_value;
         default: read_value = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         reg_rdata <= 8'h00;
      end
      else if (reg_read)
      begin
         reg_rdata <= read_value;
      end
   end

   // Waveforms: high while the counter sits below the compare value
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         wave_b <= 1'b0;
         wave_d <= 1'b0;
      end
      else
      begin
         wave_b <= counter_value < active_value[timer4_pkg::CH_B];
         wave_d <= counter_value < active_value[timer4_pkg::CH_D];
      end
   end

   // One dead-time pair each for channels B and D, both sharing the same field settings
   deadtime_if dt_link [2] ();

   generate
      for (genvar p = 0; p < 2; p++)
      begin : g_deadtime
         assign dt_link[p].waveform = (p == 0) ? wave_b : wave_d;
         assign dt_link[p].tick = timer_tick;
         assign dt_link[p].rise_delay = deadtime_value[timer4_pkg::DT_HIGH_LSB +: 4];
         assign dt_link[p].fall_delay = deadtime_value[timer4_pkg::DT_LOW_LSB +: 4];
         assign compare_output_pin[2 * p] = dt_link[p].high_out;
         assign compare_output_pin[2 * p + 1] = dt_link[p].low_out;

         deadtime_gen u_deadtime
         (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .link(dt_link[p])
         );
      end
   endgenerate

endmodule

// ### timer4_pkg.sv
package timer4_pkg;

   // Register indices on the 8-bit register port
   localparam logic [3:0] IDX_COUNTER = 4'h0;
   localparam logic [3:0] IDX_SHARED_HIGH = 4'h1;
   localparam logic [3:0] IDX_COMPARE_B = 4'h2;
   localparam logic [3:0] IDX_PERIOD_TOP = 4'h3;
   localparam logic [3:0] IDX_COMPARE_D = 4'h4;
   localparam logic [3:0] IDX_IRQ_MASK = 4'h5;
   localparam logic [3:0] IDX_IRQ_FLAGS = 4'h6;
   localparam logic [3:0] IDX_DEADTIME = 4'h7;

   // Mask and flag bit positions
   localparam int POS_MATCH_D = 7;
   localparam int POS_MATCH_A = 6;
   localparam int POS_MATCH_B = 5;
   localparam int POS_OVERFLOW = 2;
   localparam logic [7:0] IRQ_BITS_USED = 8'he4;

   // Dead-time field positions
   localparam int DT_HIGH_LSB = 4;
   localparam int DT_LOW_LSB = 0;

   // Compare channel slots
   localparam int CH_B = 0;
   localparam int CH_C = 1;
   localparam int CH_D = 2;

   // Reset values
   localparam logic [9:0] RESET_COUNTER = 10'h000;
   localparam logic [9:0] RESET_COMPARE = 10'h000;
   localparam logic [9:0] RESET_PERIOD_TOP = 10'h3ff;
   localparam logic [7:0] RESET_IRQ_MASK = 8'h00;
   localparam logic [7:0] RESET_DEADTIME = 8'h00;
   localparam logic [1:0] RESET_SHARED_HIGH = 2'h0;

   // Smallest period value the hardware keeps
   localparam logic [9:0] MIN_PERIOD_TOP = 10'h003;

   // Count direction
   typedef enum logic [1:0]
   {
      COUNT_UP = 2'b01,
      COUNT_DOWN = 2'b10
   } count_dir_type;

endpackage

// ### deadtime_if.sv
`timescale 1ns/1ns
interface deadtime_if;
   logic waveform;
   logic tick;
   logic [3:0] rise_delay;
   logic [3:0] fall_delay;
   logic high_out;
   logic low_out;

   modport source
   (
      output waveform,
      output tick,
      output rise_delay,
      output fall_delay,
      input high_out,
      input low_out
   );

   modport generator
   (
      input waveform,
      input tick,
      input rise_delay,
      input fall_delay,
      output high_out,
      output low_out
   );
endinterface

// ### deadtime_gen.sv
`timescale 1ns/1ns
module deadtime_gen
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Waveform and complementary outputs
   deadtime_if.generator link
);

   logic wave_seen;
   logic [3:0] hold;

   // Both sides stay off while the gap runs out, so they never overlap
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         wave_seen <= 1'b0;
         hold <= 4'h0;
         link.high_out <= 1'b0;
         link.low_out <= 1'b0;
      end
      else if (link.waveform != wave_seen)
      begin
         wave_seen <= link.waveform;
         hold <= link.waveform ? link.rise_delay : link.fall_delay;
         link.high_out <= 1'b0;
         link.low_out <= 1'b0;
      end
      else if (hold != 4'h0)
      begin
         if (link.tick)
         begin
            hold <= hold - 4'h1;
         end
      end
      else
      begin
         link.high_out <= wave_seen;
         link.low_out <= ~wave_seen;
      end
   end

endmodule

// ### timer4_compare_irq_deadtime_checker.sv
`timescale 1ns/1ns
module timer4_compare_checker
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [3:0] reg_index,
   input wire logic reg_write,
   input wire logic [7:0] reg_wdata,
   // Timer control
   input wire logic timer_tick,
   input wire logic pwm_enable,
   input wire logic [1:0] wave_mode,
   input wire logic match_a_event,
   input wire logic global_irq_enable,
   // Watched outputs
   input wire logic irq_match_d,
   input wire logic irq_match_a,
   input wire logic irq_match_b,
   input wire logic irq_overflow,
   input wire logic [9:0] counter_value,
   input wire logic match_b_pulse,
   input wire logic match_d_pulse,
   input wire logic top_match_pulse,
   input wire logic [3:0] compare_output_pin
);
   // Mask mirror, since the mask itself is not visible at the ports
   logic [7:0] mask_copy;
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         mask_copy <= 8'h00;
      end
      else if (reg_write && reg_index == timer4_pkg::IDX_IRQ_MASK)
      begin
         mask_copy <= reg_wdata & timer4_pkg::IRQ_BITS_USED;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_match_needs_tick: assert property ((match_b_pulse || match_d_pulse) |-> timer_tick)
      else $error("match pulse without tick");
   a_write_no_match: assert property ((reg_write && reg_index == timer4_pkg::IDX_COUNTER)
      |-> !(match_b_pulse || match_d_pulse)) else $error("counter write made a match");
   a_irq_b_sync: assert property (($rose(irq_match_b) && $stable(global_irq_enable)
      && !$past(reg_write)) |-> $past(match_b_pulse, 2)) else $error("flag b not synced");
   a_irq_d_sync: assert property (($rose(irq_match_d) && $stable(global_irq_enable)
      && !$past(reg_write)) |-> $past(match_d_pulse, 2)) else $error("flag d not synced");
   a_irq_a_sets: assert property (match_a_event ##2 (global_irq_enable && mask_copy[6])
      |-> irq_match_a) else $error("flag a not set");
   a_gate_d: assert property (!(global_irq_enable && mask_copy[7]) |-> !irq_match_d)
      else $error("request d not gated");
   a_gate_b: assert property (!(global_irq_enable && mask_copy[5]) |-> !irq_match_b)
      else $error("request b not gated");
   a_gate_ovf: assert property (!(global_irq_enable && mask_copy[2]) |-> !irq_overflow)
      else $error("overflow request not gated");
   a_gate_a: assert property (!(global_irq_enable && mask_copy[6]) |-> !irq_match_a)
      else $error("request a not gated");
   a_top_clears: assert property ((top_match_pulse && !(pwm_enable && wave_mode[0])
      && !reg_write) |=> counter_value == 10'h000) else $error("period did not clear");
   a_overflow_wrap: assert property ((counter_value == 10'h000 && $past(counter_value) != 0
      && !$past(reg_write) && global_irq_enable && mask_copy[2]) |-> irq_overflow)
      else $error("no overflow at bottom");
   a_dead_gap_b: assert property (!(compare_output_pin[0] && compare_output_pin[1]))
      else $error("channel b sides overlap");
   a_dead_gap_d: assert property (!(compare_output_pin[2] && compare_output_pin[3]))
      else $error("channel d sides overlap");
   c_match_b: cover property (match_b_pulse);
   c_overflow: cover property ($rose(irq_overflow));
   c_low_side: cover property ($rose(compare_output_pin[1]));
endmodule

// ### reg_master_model.sv
`timescale 1ns/1ns
module reg_master_model
(
   // Clock
   input wire logic ref_clk,
   // Register port
   output logic [3:0] reg_index,
   output logic reg_write,
   output logic reg_read,
   output logic [7:0] reg_wdata
);
   initial
   begin
      reg_index = 4'h0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_wdata = 8'h00;
   end
   // Two cycles per access so a strobe is never set twice in one step
   task automatic wr(input logic [3:0] idx, input logic [7:0] data);
      reg_index = idx;
      reg_wdata = data;
      reg_write = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_write = 1'b0;
      reg_wdata = ~data;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic rd(input logic [3:0] idx);
      reg_index = idx;
      reg_read = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_read = 1'b0;
      @(posedge ref_clk);
      #1;
   endtask
   // High bits first, the low byte commits the whole value
   task automatic wr10(input logic [3:0] idx, input logic [9:0] data);
      wr(timer4_pkg::IDX_SHARED_HIGH, {6'h00, data[9:8]});
      wr(idx, data[7:0]);
   endtask
endmodule

// ### timer4_compare_irq_deadtime_test.sv
`timescale 1ns/1ns
module timer4_compare_irq_deadtime_test;
   logic ref_clk, rst_n, timer_tick, pwm_enable, match_a_event, global_irq_enable;
   logic vector_ack_d, vector_ack_a, vector_ack_b, vector_ack_overflow;
   logic reg_write, reg_read, irq_match_d, irq_match_a, irq_match_b, irq_overflow;
   logic match_b_pulse, match_d_pulse, top_match_pulse, seen_hi, seen_lo;
   logic [1:0] wave_mode;
   logic [3:0] reg_index, compare_output_pin;
   logic [7:0] reg_wdata, reg_rdata;
   logic [9:0] counter_value;
   logic [9:0] expq[$];
   int err_total, tests_run, cycles;
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   reg_master_model u_reg_master_model (.ref_clk, .reg_index, .reg_write, .reg_read, .reg_wdata);
   timer4_compare_unit u_timer4_compare_unit (.ref_clk, .rst_n, .reg_index, .reg_write,
      .reg_read, .reg_wdata, .reg_rdata, .timer_tick, .pwm_enable, .wave_mode, .match_a_event,
      .global_irq_enable, .vector_ack_d, .vector_ack_a, .vector_ack_b, .vector_ack_overflow,
      .irq_match_d, .irq_match_a, .irq_match_b, .irq_overflow, .counter_value, .match_b_pulse,
      .match_d_pulse, .top_match_pulse, .compare_output_pin);
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n)
      begin
         @(posedge ref_clk);
         #1;
      end
   endtask
   task automatic rdx(input logic [3:0] idx, input logic [9:0] exp);
      expq.push_back(exp);
      u_reg_master_model.rd(idx);
   endtask
   task automatic print_verdict;
      if (err_total == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Read results land one edge after the strobe
   always @(posedge ref_clk)
   begin
      if (reg_read === 1'b1 && expq.size() > 0)
      begin
         #3;
         check({2'b00, reg_rdata}, expq.pop_front());
      end
   end
   always @(posedge ref_clk)
   begin
      cycles++;
      seen_hi |= compare_output_pin[0];
      seen_lo |= compare_output_pin[1];
      if (cycles == 2000)
      begin
         err_total++;
         print_verdict();
      end
   end
   initial
   begin
      {rst_n, timer_tick, pwm_enable, match_a_event, global_irq_enable} = 5'h00;
      {vector_ack_d, vector_ack_a, vector_ack_b, vector_ack_overflow} = 4'h0;
      {seen_hi, seen_lo, wave_mode} = 4'h0;
      {err_total, tests_run, cycles} = {32'h0, 32'h0, 32'h0};
      void'($urandom(32'hda978f7a));
      step(5);
      rst_n = 1'b1;
      rdx(timer4_pkg::IDX_IRQ_MASK, 10'h000);
      rdx(timer4_pkg::IDX_IRQ_FLAGS, 10'h000);
      rdx(timer4_pkg::IDX_DEADTIME, 10'h000);
      rdx(timer4_pkg::IDX_PERIOD_TOP, 10'h0ff);
      rdx(timer4_pkg::IDX_SHARED_HIGH, 10'h003);
      rdx(4'h8, 10'h000);
      for (int v = 4; v >= 0; v--)
      begin
         u_reg_master_model.wr10(timer4_pkg::IDX_PERIOD_TOP, 10'(v));
         rdx(timer4_pkg::IDX_PERIOD_TOP, (v < 3) ? 10'h003 : 10'(v));
      end
      u_reg_master_model.wr10(timer4_pkg::IDX_COMPARE_B, 10'h002);
      u_reg_master_model.wr10(timer4_pkg::IDX_COMPARE_D, 10'h001);
      u_reg_master_model.wr(timer4_pkg::IDX_IRQ_MASK, 8'hff);
      rdx(timer4_pkg::IDX_IRQ_MASK, 10'h0e4);
      global_irq_enable = 1'b1;
      timer_tick = 1'b1;
      step(1);
      check(10'(match_b_pulse), 10'h001);
      check(10'(irq_match_d), 10'h000);
      step(3);
      timer_tick = 1'b0;
      check(counter_value, 10'h000);
      check(10'({irq_match_d, irq_match_b, irq_overflow}), 10'h007);
      rdx(timer4_pkg::IDX_IRQ_FLAGS, 10'h0a4);
      global_irq_enable = 1'b0;
      step(1);
      check(10'({irq_match_d, irq_match_b, irq_overflow}), 10'h000);
      global_irq_enable = 1'b1;
      u_reg_master_model.wr(timer4_pkg::IDX_IRQ_FLAGS, 8'h00);
      rdx(timer4_pkg::IDX_IRQ_FLAGS, 10'h0a4);
      vector_ack_overflow = 1'b1;
      step(1);
      vector_ack_overflow = 1'b0;
      check(10'(irq_overflow), 10'h000);
      u_reg_master_model.wr(timer4_pkg::IDX_IRQ_FLAGS, 8'h20);
      rdx(timer4_pkg::IDX_IRQ_FLAGS, 10'h080);
      match_a_event = 1'b1;
      step(1);
      match_a_event = 1'b0;
      check(10'(irq_match_a), 10'h000);
      step(1);
      check(10'(irq_match_a), 10'h001);
      {vector_ack_d, vector_ack_a, vector_ack_b} = 3'h7;
      step(1);
      {vector_ack_d, vector_ack_a, vector_ack_b} = 3'h0;
      rdx(timer4_pkg::IDX_IRQ_FLAGS, 10'h000);
      u_reg_master_model.wr(timer4_pkg::IDX_SHARED_HIGH, 8'h00);
      timer_tick = 1'b1;
      // Load lands on the edge where the step would reach compare D
      fork
         u_reg_master_model.wr(timer4_pkg::IDX_COUNTER, 8'h01);
         begin
            step(1);
            timer_tick = 1'b0;
         end
      join
      step(2);
      rdx(timer4_pkg::IDX_IRQ_FLAGS, 10'h000);
      {pwm_enable, wave_mode, timer_tick} = 4'hb;
      step(3);
      timer_tick = 1'b0;
      check(counter_value, 10'h002);
      check(10'(irq_overflow), 10'h000);
      timer_tick = 1'b1;
      step(2);
      timer_tick = 1'b0;
      check(10'({counter_value, irq_overflow}), 10'h001);
      {pwm_enable, wave_mode} = 3'h0;
      u_reg_master_model.wr10(timer4_pkg::IDX_PERIOD_TOP, 10'h01f);
      u_reg_master_model.wr10(timer4_pkg::IDX_COMPARE_B, 10'h010);
      u_reg_master_model.wr(timer4_pkg::IDX_DEADTIME, 8'h52);
      rdx(timer4_pkg::IDX_DEADTIME, 10'h052);
      {pwm_enable, wave_mode} = 3'h4;
      {seen_hi, seen_lo} = 2'b00;
      repeat (300)
      begin
         timer_tick = 1'($urandom);
         step(1);
      end
      timer_tick = 1'b0;
      check(10'({seen_hi, seen_lo}), 10'h003);
      print_verdict();
   end
endmodule
bind timer4_compare_unit timer4_compare_checker u_timer4_compare_checker (.ref_clk, .rst_n,
   .reg_index, .reg_write, .reg_wdata, .timer_tick, .pwm_enable, .wave_mode, .match_a_event,
   .global_irq_enable, .irq_match_d, .irq_match_a, .irq_match_b, .irq_overflow, .counter_value,
   .match_b_pulse, .match_d_pulse, .top_match_pulse, .compare_output_pin);
